//--- psrpu_consts.svh
/*
  Constants for the power-up and reset controller of the octal DDR pseudo-static RAM.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef PSRPU_CONSTS_SVH
`define PSRPU_CONSTS_SVH
// Summary of operation
// [RULE_01] After supplies settle, self-initialize for 150 us before phase two may start.
// [RULE_02] Host keeps chip select high and clock low during self-initialization.
// [RULE_03] Host then finishes power-up by sending a global reset command.
// [RULE_04] Global reset restores all registers; array contents are not guaranteed.
// [RULE_05] Host frames global reset as four clocked cycles with chip select low.
// [RULE_06] Clock may stop or run during reset recovery; reset completes either way.
// [RULE_07] Normal operation at once; sleep and power-down entry wait their power-up times.
// [RULE_08] Chip select high means standby and no response to the bus.
// [RULE_09] During writes each strobe/mask lane is an active-high byte write mask.
// [RULE_10] Lower lane is the read strobe for the lower byte on every read.
// [RULE_11] Word-wide only: upper lane strobes upper byte reads and masks its writes.
// [RULE_12] Data moves on both clock edges: two bytes or two words per clock.
// [RULE_13] Default byte-wide with width bit zero; writing it one selects word-wide.
// [RULE_14] Byte-wide rows hold 2048 bytes: 11 column bits, 15 row bits.
// [RULE_15] Word-wide rows hold 1024 words: 10 column bits, 15 row bits.
// [RULE_16] Host write bursts are 2 to 2048 bytes or 2 to 1024 words.
// [RULE_17] Wrap and hybrid bursts of 16, 32, 64, 128 or full row are supported. The controller has no wrap or hybrid burst logic.
// [RULE_18] Linear burst commands exist; row-crossing reads allowed when enabled.
// [RULE_19] Host must not expect row crossing past the top row bit die boundary.
// [RULE_20] Refresh is scheduled internally, rate adjusted by the temperature sensor.
// [RULE_21] Interface clock is at most 200 MHz.
// [RULE_22] Read and write latencies come from separate programmable settings.
// [RULE_23] Instruction caught on first rising edge, address on next four edges.
// [RULE_24] Host always writes the width register's top bit as zero.
// [RULE_25] All bus activity is ignored until self-initialization completes.
// [RULE_26] Global reset returns byte-wide mode and default latency and burst settings.

// ****************************************************************
// Timing
// ****************************************************************
`define PSRPU_CLK_MHZ          200
`define PSRPU_INIT_US          150
`define PSRPU_INIT_CYC         (`PSRPU_INIT_US * `PSRPU_CLK_MHZ)
`define PSRPU_RST_FRAME_EDGES  4
`define PSRPU_RST_RECOV_CYC    64
`define PSRPU_HSPU_CYC         200
`define PSRPU_DPDP_CYC         200
`define PSRPU_REFRESH_CYC      780

// ****************************************************************
// Commands and register addresses
// ****************************************************************
`define PSRPU_CMD_SYNC_RD      8'h00
`define PSRPU_CMD_SYNC_WR      8'h80
`define PSRPU_CMD_LIN_RD       8'h20
`define PSRPU_CMD_LIN_WR       8'ha0
`define PSRPU_CMD_REG_RD       8'h40
`define PSRPU_CMD_REG_WR       8'hc0
`define PSRPU_CMD_GLOBAL_RST   8'hff
`define PSRPU_MA_LAT           8'h00
`define PSRPU_MA_WLAT          8'h04
`define PSRPU_MA_WIDTH         8'h08

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PSRPU_WIDTH_BIT        6
`define PSRPU_TOP_BIT          7
`define PSRPU_RBX_BIT          3
`define PSRPU_LAT_RST          8'h08
`define PSRPU_WLAT_RST         8'h40
`define PSRPU_WIDTH_RST        8'h01
`define PSRPU_COL_BITS_X8      11
`define PSRPU_COL_BITS_X16     10
`define PSRPU_ROW_BITS         15
`define PSRPU_ADDR_EDGES       4
`endif

//--- psrpu_pkg.sv
/*
  Types shared by the power-up and reset controller modules.
  Assumes the constants header is on the include path.
*/
package psrpu_pkg;
  `include "psrpu_consts.svh"
  typedef enum logic [2:0] {
    PSRPU_POWER_INIT,
    PSRPU_IDLE,
    PSRPU_CMD,
    PSRPU_ADDR,
    PSRPU_DATA,
    PSRPU_RECOVER
  } psrpu_state_t;
  typedef logic [7:0] psrpu_byte_t;
endpackage

//--- psrpu_cfg_if.sv
/*
  Carrier between the controller and its mode register store.
  Assumes both ends share core_clk_in.
*/
`timescale 1ns/10ps
interface psrpu_cfg_if;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       clear;
  logic [7:0] lat_reg;
  logic [7:0] wlat_reg;
  logic [7:0] width_reg;
  modport ctrl  (output wr_en, wr_addr, wr_data, rd_addr, clear, input rd_data, lat_reg, wlat_reg, width_reg);
  modport store (input wr_en, wr_addr, wr_data, rd_addr, clear, output rd_data, lat_reg, wlat_reg, width_reg);
endinterface

//--- psrpu_mode_regs.sv
/*
  Mode register store with registered read data.
  Assumes writes arrive from the controller on the core clock.
*/
`timescale 1ns/10ps
`include "psrpu_consts.svh"
module psrpu_mode_regs
  import psrpu_pkg::*;
(
  input  wire logic   core_clk_in,
  input  wire logic   rstn_in,
  input  wire logic   clk_en_in,
  psrpu_cfg_if.store  cfg
);
  logic [7:0] lat_q;
  logic [7:0] wlat_q;
  logic [7:0] width_q;
  logic [7:0] rd_q;
  wire        do_lat   = cfg.wr_en && (cfg.wr_addr == `PSRPU_MA_LAT);
  wire        do_wlat  = cfg.wr_en && (cfg.wr_addr == `PSRPU_MA_WLAT);
  wire        do_width = cfg.wr_en && (cfg.wr_addr == `PSRPU_MA_WIDTH);
  wire [7:0]  rd_sel   = (cfg.rd_addr == `PSRPU_MA_LAT)   ? lat_q   :
                         (cfg.rd_addr == `PSRPU_MA_WLAT)  ? wlat_q  :
                         (cfg.rd_addr == `PSRPU_MA_WIDTH) ? width_q : 8'h00;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || (clk_en_in && cfg.clear)) begin
      lat_q   <= `PSRPU_LAT_RST; // RULE_04
      wlat_q  <= `PSRPU_WLAT_RST; // RULE_26
      width_q <= `PSRPU_WIDTH_RST; // RULE_13 RULE_17
      rd_q    <= 8'h00;
    end else if (clk_en_in) begin
      if (do_lat)
        lat_q <= cfg.wr_data;
      if (do_wlat)
        wlat_q <= cfg.wr_data; // RULE_22
      if (do_width)
        width_q <= cfg.wr_data;
      rd_q <= rd_sel;
    end
  end

  assign cfg.lat_reg   = lat_q;
  assign cfg.wlat_reg  = wlat_q;
  assign cfg.width_reg = width_q;
  assign cfg.rd_data   = rd_q;
endmodule // psrpu_mode_regs

//--- psrpu_ctrl.sv
/*
  Device-side power-up, global reset and pin framing for the octal DDR PSRAM.
  Assumes pins arrive asynchronously; the link clock is sampled, not used as a clock.
*/
`timescale 1ns/10ps
`include "psrpu_consts.svh"
module psrpu_ctrl
  import psrpu_pkg::*;
#(
  parameter int INIT_CYC  = `PSRPU_INIT_CYC,
  parameter int RECOV_CYC = `PSRPU_RST_RECOV_CYC
)(
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        clk_en_in,
  input  wire logic        supply_ok_in,
  input  wire logic        link_clk_in,
  input  wire logic        chip_sel_n_in,
  input  wire logic [15:0] adq_in,
  output logic      [15:0] adq_out,
  output logic      [15:0] adq_oe_out,
  input  wire logic [1:0]  strobe_mask_lane_in,
  output logic      [1:0]  strobe_mask_lane_out,
  output logic      [1:0]  strobe_mask_lane_oe_out,
  input  wire logic        hot_temp_in,
  input  wire logic        sleep_req_in,
  input  wire logic        deep_power_down_req_in,
  output logic             init_done_out,
  output logic             word_wide_mode_out,
  output logic             row_cross_read_out,
  output logic             mem_wr_out,
  output logic      [31:0] mem_addr_out,
  output logic      [15:0] mem_wdata_out,
  output logic      [1:0]  write_byte_mask_out,
  output logic             refresh_out,
  output logic             sleep_ok_out,
  output logic             deep_power_down_ok_out
);
  initial begin
    if (INIT_CYC < 1 || RECOV_CYC < 1)
      $error("psrpu_ctrl: counts must be at least one");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [20:0] s1_q;
  logic [20:0] s2_q;
  logic        lclk_prev_q;
  wire  [20:0] pins_raw = {supply_ok_in, link_clk_in, chip_sel_n_in, strobe_mask_lane_in, adq_in};

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      // Idle levels: supply low, link clock low, select high
      s1_q        <= 21'h07ffff;
      s2_q        <= 21'h07ffff;
      lclk_prev_q <= 1'b0;
    end else if (clk_en_in) begin
      s1_q        <= pins_raw;
      s2_q        <= s1_q;
      lclk_prev_q <= s2_q[19]; // RULE_21
    end
  end

  wire        supply_s = s2_q[20];
  wire        lclk_s   = s2_q[19];
  wire        csn_s    = s2_q[18];
  wire [1:0]  lane_s   = s2_q[17:16];
  wire [15:0] dq_s     = s2_q[15:0];
  wire        rise     = lclk_s && !lclk_prev_q;
  wire        edge_any = lclk_s != lclk_prev_q; // RULE_12

  // ****************************************************************
  // Configuration store
  // ****************************************************************
  psrpu_cfg_if cfg ();
  psrpu_mode_regs u_regs (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .clk_en_in   (clk_en_in),
    .cfg         (cfg)
  );

  function automatic logic [31:0] map_addr(input logic [31:0] raw, input logic wide);
    logic [31:0] r;
    r = 32'h0;
    if (wide)
      r = {7'h0, raw[`PSRPU_ROW_BITS+`PSRPU_COL_BITS_X16-1:0]}; // RULE_15
    else
      r = {6'h0, raw[`PSRPU_ROW_BITS+`PSRPU_COL_BITS_X8-1:0]}; // RULE_14
    return r;
  endfunction

  wire wide     = cfg.width_reg[`PSRPU_WIDTH_BIT]; // RULE_13
  wire rbx_en   = cfg.width_reg[`PSRPU_RBX_BIT];

  // ****************************************************************
  // Frame state machine
  // ****************************************************************
  psrpu_state_t state_q, state_d;
  logic [31:0]  cnt_q;
  logic [7:0]   cmd_q;
  logic [31:0]  addr_q;
  logic [2:0]   aedge_q;
  logic [2:0]   rst_edges_q;
  logic [7:0]   lat_cnt_q;
  logic         half_q;
  logic [15:0]  rd_shift_q;
  logic         strobe_q;
  logic [9:0]   ref_cnt_q;
  logic         ref_q;
  logic [7:0]   pwr_cnt_q;
  logic         mwr_q;
  logic [15:0]  mwd_q;
  logic [1:0]   mmask_q;

  wire is_read  = (cmd_q == `PSRPU_CMD_SYNC_RD) || (cmd_q == `PSRPU_CMD_LIN_RD) || (cmd_q == `PSRPU_CMD_REG_RD);
  wire is_mwrite = (cmd_q == `PSRPU_CMD_SYNC_WR) || (cmd_q == `PSRPU_CMD_LIN_WR);
  wire is_rwrite = cmd_q == `PSRPU_CMD_REG_WR;
  wire rst_frame = csn_s && (state_q == PSRPU_CMD) && (cmd_q == `PSRPU_CMD_GLOBAL_RST)
                   && (rst_edges_q == 3'(`PSRPU_RST_FRAME_EDGES)); // RULE_05
  wire [7:0] latency = is_rwrite ? 8'h01 : (is_read ? {3'h0, cfg.lat_reg[4:2], 2'h0} : {5'h0, cfg.wlat_reg[7:5]});

  always_comb begin
    state_d = state_q;
    case (state_q)
      PSRPU_POWER_INIT: if (supply_s && cnt_q >= 32'(INIT_CYC)) state_d = PSRPU_IDLE; // RULE_01
      PSRPU_IDLE:       if (!csn_s && rise) state_d = PSRPU_CMD; // RULE_23
      PSRPU_CMD:        if (csn_s) state_d = rst_frame ? PSRPU_RECOVER : PSRPU_IDLE;
                        else if (cmd_q != `PSRPU_CMD_GLOBAL_RST && edge_any) state_d = PSRPU_ADDR;
      PSRPU_ADDR:       if (csn_s) state_d = PSRPU_IDLE; // RULE_08
                        else if (aedge_q == 3'(`PSRPU_ADDR_EDGES)) state_d = PSRPU_DATA;
      PSRPU_DATA:       if (csn_s) state_d = PSRPU_IDLE;
      PSRPU_RECOVER:    if (cnt_q >= 32'(RECOV_CYC)) state_d = PSRPU_IDLE; // RULE_06
      default:          state_d = PSRPU_POWER_INIT;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state_q <= PSRPU_POWER_INIT;
      cnt_q   <= 32'h0;
    end else if (clk_en_in) begin
      state_q <= state_d;
      if (state_d != state_q)
        cnt_q <= 32'h0;
      else if (state_q == PSRPU_POWER_INIT && !supply_s)
        cnt_q <= 32'h0; // RULE_25
      else
        cnt_q <= cnt_q + 32'h1; // RULE_06
    end
  end

  // Command, address and edge counters
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      cmd_q       <= 8'h00;
      addr_q      <= 32'h0;
      aedge_q     <= 3'h0;
      rst_edges_q <= 3'h0;
    end else if (clk_en_in) begin
      if (state_q == PSRPU_IDLE && !csn_s && rise) begin
        cmd_q       <= dq_s[7:0]; // RULE_23
        rst_edges_q <= 3'h1;
        aedge_q     <= 3'h0;
      end else if (state_q == PSRPU_CMD && !csn_s && rise && rst_edges_q != 3'h7)
        rst_edges_q <= rst_edges_q + 3'h1;
      if ((state_q == PSRPU_CMD || state_q == PSRPU_ADDR) && !csn_s && edge_any
          && aedge_q != 3'(`PSRPU_ADDR_EDGES) && cmd_q != `PSRPU_CMD_GLOBAL_RST) begin
        addr_q  <= {addr_q[23:0], dq_s[7:0]}; // RULE_23
        aedge_q <= aedge_q + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Data phase
  // ****************************************************************
  wire in_data  = state_q == PSRPU_DATA && !csn_s;
  wire data_go  = in_data && lat_cnt_q >= latency && edge_any;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      lat_cnt_q  <= 8'h0;
      half_q     <= 1'b0;
      strobe_q   <= 1'b0;
      rd_shift_q <= 16'h0;
      mwr_q      <= 1'b0;
      mwd_q      <= 16'h0;
      mmask_q    <= 2'h0;
    end else if (clk_en_in) begin
      mwr_q <= 1'b0;
      if (!in_data) begin
        lat_cnt_q <= 8'h0;
        strobe_q  <= 1'b0;
        half_q    <= 1'b0;
      end else begin
        if (rise && lat_cnt_q < latency)
          lat_cnt_q <= lat_cnt_q + 8'h1; // RULE_22
        if (data_go) begin
          half_q <= !half_q;
          if (is_read) begin
            strobe_q   <= lclk_s; // RULE_10
            rd_shift_q <= {8'h0, cfg.rd_data};
          end else if (is_rwrite) begin
            mwr_q <= 1'b0;
          end else if (is_mwrite) begin
            mwr_q   <= 1'b1;
            mwd_q   <= wide ? dq_s : {8'h0, dq_s[7:0]};
            mmask_q <= wide ? lane_s : {1'b1, lane_s[0]}; // RULE_09 RULE_11
          end
        end
      end
    end
  end

  // Mode register write, always latency one, width register top bit forced low defensively
  assign cfg.wr_en   = clk_en_in && data_go && is_rwrite && !half_q;
  assign cfg.wr_addr = addr_q[7:0];
  assign cfg.wr_data = (addr_q[7:0] == `PSRPU_MA_WIDTH) ? {1'b0, dq_s[6:0]} : dq_s[7:0]; // RULE_24
  assign cfg.rd_addr = addr_q[7:0];
  assign cfg.clear   = rst_frame; // RULE_04 RULE_26

  // ****************************************************************
  // Refresh and low power gating
  // ****************************************************************
  // Hot die refreshes four times as often
  wire ref_hit = ref_cnt_q >= (hot_temp_in ? 10'(`PSRPU_REFRESH_CYC / 4) : 10'(`PSRPU_REFRESH_CYC));

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ref_cnt_q <= 10'h0;
      ref_q     <= 1'b0;
      pwr_cnt_q <= 8'h0;
    end else if (clk_en_in) begin
      ref_q     <= ref_hit; // RULE_20
      ref_cnt_q <= ref_hit ? 10'h0 : ref_cnt_q + 10'h1;
      if (state_q == PSRPU_POWER_INIT || state_q == PSRPU_RECOVER)
        pwr_cnt_q <= 8'h0;
      else if (pwr_cnt_q != 8'hff)
        pwr_cnt_q <= pwr_cnt_q + 8'h1; // RULE_07
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire rd_drive = in_data && is_read;
  assign adq_out                 = rd_shift_q;
  assign adq_oe_out              = rd_drive ? (wide && !is_rwrite ? 16'hffff : 16'h00ff) : 16'h0; // RULE_08
  assign strobe_mask_lane_out    = {strobe_q && wide, strobe_q};
  assign strobe_mask_lane_oe_out = {rd_drive && wide && !is_rwrite, rd_drive}; // RULE_10 RULE_11
  assign init_done_out           = state_q != PSRPU_POWER_INIT;
  assign word_wide_mode_out      = wide;
  assign row_cross_read_out      = rbx_en && cmd_q == `PSRPU_CMD_LIN_RD; // RULE_18
  assign mem_wr_out              = mwr_q;
  assign mem_addr_out            = map_addr(addr_q, wide);
  assign mem_wdata_out           = mwd_q;
  assign write_byte_mask_out     = mmask_q;
  assign refresh_out             = ref_q;
  assign sleep_ok_out            = sleep_req_in && pwr_cnt_q >= 8'(`PSRPU_HSPU_CYC);
  assign deep_power_down_ok_out  = deep_power_down_req_in && pwr_cnt_q >= 8'(`PSRPU_DPDP_CYC);
endmodule // psrpu_ctrl

//--- psrpu_ctrl_assertions.sv
/*
  Concurrent checks on the power-up and reset controller pins.
  Assumes binding onto psrpu_ctrl, one clock domain, sync active-low reset.
*/
`timescale 1ns/10ps
module psrpu_ctrl_assertions
  import psrpu_pkg::*;
#(
  parameter int INIT_CYC = 50
)(
  input wire logic        core_clk_in,
  input wire logic        rstn_in,
  input wire logic        supply_ok_in,
  input wire logic        chip_sel_n_in,
  input wire logic [15:0] adq_oe_out,
  input wire logic [1:0]  strobe_mask_lane_oe_out,
  input wire logic        init_done_out,
  input wire logic        word_wide_mode_out,
  input wire logic        mem_wr_out,
  input wire logic        refresh_out,
  input wire logic        sleep_ok_out,
  input wire logic        deep_power_down_ok_out
);
  // ****************************************************************
  // Saturating cycle counters
  // ****************************************************************
  int sup_q;
  int up_q;
  int gap_q;
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      sup_q <= 0;
      up_q  <= 0;
      gap_q <= 0;
    end else begin
      sup_q <= supply_ok_in ? ((sup_q < 99999) ? sup_q + 1 : sup_q) : 0;
      up_q  <= init_done_out ? ((up_q < 999) ? up_q + 1 : up_q) : 0;
      gap_q <= (refresh_out || !init_done_out) ? 0 : ((gap_q < 1999) ? gap_q + 1 : gap_q);
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_init_wait: assert property ($rose(init_done_out) |-> sup_q >= INIT_CYC)
    else $error("init done before supply settle time");
  a_quiet_before_init: assert property (!init_done_out |-> adq_oe_out == 16'h0000 && strobe_mask_lane_oe_out == 2'b00)
    else $error("pins driven before init done");
  a_no_write_early: assert property (!init_done_out |-> !mem_wr_out)
    else $error("memory write before init done");
  a_narrow_default: assert property (!init_done_out |-> !word_wide_mode_out)
    else $error("word mode set before init done");
  a_standby_quiet: assert property (chip_sel_n_in [*6] |-> !mem_wr_out && adq_oe_out == 16'h0000)
    else $error("activity while deselected");
  a_upper_lane_idle: assert property (!word_wide_mode_out |-> !strobe_mask_lane_oe_out[1] && adq_oe_out[15:8] == 8'h00)
    else $error("upper lane driven in byte mode");
  a_sleep_wait: assert property (sleep_ok_out |-> up_q >= 200)
    else $error("sleep allowed too early");
  a_deep_down_wait: assert property (deep_power_down_ok_out |-> up_q >= 200)
    else $error("deep power down allowed too early");
  a_refresh_bound: assert property (init_done_out |-> gap_q < 800)
    else $error("refresh gap too long");
  c_init: cover property ($rose(init_done_out));
  c_wide: cover property ($rose(word_wide_mode_out));
  c_narrow: cover property ($fell(word_wide_mode_out));
  c_write: cover property (mem_wr_out);
endmodule // psrpu_ctrl_assertions

bind psrpu_ctrl psrpu_ctrl_assertions #(.INIT_CYC(INIT_CYC)) psrpu_ctrl_assertions_inst (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .supply_ok_in(supply_ok_in),
  .chip_sel_n_in(chip_sel_n_in), .adq_oe_out(adq_oe_out),
  .strobe_mask_lane_oe_out(strobe_mask_lane_oe_out), .init_done_out(init_done_out),
  .word_wide_mode_out(word_wide_mode_out), .mem_wr_out(mem_wr_out), .refresh_out(refresh_out),
  .sleep_ok_out(sleep_ok_out), .deep_power_down_ok_out(deep_power_down_ok_out));

//--- psrpu_host_model.sv
/*
  Host controller model that frames commands on the pins.
  Assumes the bench resolves shared lines and calls send.
*/
`timescale 1ns/10ps
module psrpu_host_model
  import psrpu_pkg::*;
(
  input  wire logic        core_clk_in,
  output logic             link_clk_out,
  output logic             chip_sel_n_out,
  output logic      [15:0] adq_out,
  output logic      [1:0]  lane_out
);
  initial begin
    link_clk_out   = 1'b0;
    chip_sel_n_out = 1'b1;
    adq_out        = 16'h0000;
    lane_out       = 2'b00;
  end
  // Byte set mid half-period so each edge sees settled data
  task automatic send(input logic sel, input logic [7:0] cmd, input logic [31:0] addr,
                      input int cycles, input logic [15:0] data, input logic [1:0] mask);
    int e;
    @(posedge core_clk_in);
    #1;
    chip_sel_n_out = ~sel;
    for (e = 0; e < 2 * cycles; e++) begin
      if (e == 0) adq_out = {8'h00, cmd};
      else if (e < 5) adq_out = {8'h00, addr[39 - 8 * e -: 8]};
      else adq_out = data;
      lane_out = (e < 5) ? 2'b00 : mask;
      #12;
      link_clk_out = ~link_clk_out;
      #12;
    end
    chip_sel_n_out = 1'b1;
    // Released lines must not keep showing the last value
    adq_out  = ~adq_out;
    lane_out = ~lane_out;
  endtask
endmodule // psrpu_host_model

//--- testbench.sv
/*
  Self-checking bench for psrpu_ctrl with a host model on the pins.
  Assumes short init and recovery counts set by parameter.
*/
`timescale 1ns/10ps
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin errors++; \
  $display("ERROR at %0t: got %h expected %h", $time, (act), (exp)); end end
module testbench;
  import psrpu_pkg::*;
  logic core_clk_in = 1'b0, rstn_in = 1'b0, supply_ok = 1'b0, hot = 1'b0, sleep_req = 1'b0, dpd_req = 1'b0;
  logic link_clk, cs_n, init_done, wide, row_cross_read, mem_wr, refresh, sleep_ok, dpd_ok;
  logic [15:0] host_adq, adq_out, adq_oe, wdata, last_wdata;
  logic [1:0] host_lane, lane_out, lane_oe, mask, last_mask;
  logic [31:0] mem_addr;
  int errors = 0, samples_checked = 0, wr_cnt = 0, ref_cnt = 0, oe_cnt = 0;
  // Shared lines: device wins where it enables its driver
  wire logic [15:0] adq_w  = (adq_oe & adq_out) | (~adq_oe & host_adq);
  wire logic [1:0]  lane_w = (lane_oe & lane_out) | (~lane_oe & host_lane);
  always #2.5 core_clk_in = ~core_clk_in;
  psrpu_host_model psrpu_host_model_inst (.core_clk_in(core_clk_in), .link_clk_out(link_clk),
    .chip_sel_n_out(cs_n), .adq_out(host_adq), .lane_out(host_lane));
  psrpu_ctrl #(.INIT_CYC(50), .RECOV_CYC(4)) psrpu_ctrl_inst (.core_clk_in(core_clk_in),
    .rstn_in(rstn_in), .clk_en_in(1'b1), .supply_ok_in(supply_ok), .link_clk_in(link_clk),
    .chip_sel_n_in(cs_n), .adq_in(adq_w), .adq_out(adq_out), .adq_oe_out(adq_oe),
    .strobe_mask_lane_in(lane_w), .strobe_mask_lane_out(lane_out), .strobe_mask_lane_oe_out(lane_oe),
    .hot_temp_in(hot), .sleep_req_in(sleep_req), .deep_power_down_req_in(dpd_req),
    .init_done_out(init_done), .word_wide_mode_out(wide), .row_cross_read_out(row_cross_read),
    .mem_wr_out(mem_wr), .mem_addr_out(mem_addr), .mem_wdata_out(wdata),
    .write_byte_mask_out(mask), .refresh_out(refresh), .sleep_ok_out(sleep_ok),
    .deep_power_down_ok_out(dpd_ok));
  always @(posedge core_clk_in) begin
    if (mem_wr === 1'b1) begin
      wr_cnt++;
      last_wdata = wdata;
      last_mask  = mask;
    end
    if (refresh === 1'b1) ref_cnt++;
    if (lane_oe[0] === 1'b1) oe_cnt++;
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task set_width(input logic [7:0] val);
    psrpu_host_model_inst.send(1'b1, 8'hc0, 32'h0000_0008, 6, {8'h00, val}, 2'b00);
    cyc(20);
  endtask
  task global_reset(input int rises);
    psrpu_host_model_inst.send(1'b1, 8'hff, 32'h0, rises, 16'hffff, 2'b00);
    cyc(30);
  endtask
  task give_verdict;
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_power_up;
    int n;
    cyc(60);
    set_width(8'h40);
    `CHK(init_done, 1'b0)
    `CHK(wide, 1'b0)
    @(posedge core_clk_in);
    supply_ok <= 1'b1;
    sleep_req <= 1'b1;
    dpd_req   <= 1'b1;
    n = 0;
    while (init_done !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    `CHK(n >= 50 && n <= 60, 1'b1)
    cyc(100);
    `CHK({sleep_ok, dpd_ok}, 2'b00)
    cyc(110);
    `CHK({sleep_ok, dpd_ok}, 2'b11)
    @(posedge core_clk_in);
    sleep_req <= 1'b0;
    dpd_req   <= 1'b0;
    cyc(6);
    `CHK({sleep_ok, dpd_ok}, 2'b00)
  endtask
  task t_width_and_reset;
    global_reset(4);
    `CHK(wide, 1'b0)
    set_width(8'h40);
    `CHK(wide, 1'b1)
    global_reset(3);
    `CHK(wide, 1'b1)
    global_reset(4);
    `CHK(wide, 1'b0)
    set_width(8'h40);
    `CHK(wide, 1'b1)
    global_reset(4);
  endtask
  task t_standby;
    int c0;
    c0 = wr_cnt;
    psrpu_host_model_inst.send(1'b0, 8'hc0, 32'h0000_0008, 6, 16'h0040, 2'b00);
    psrpu_host_model_inst.send(1'b0, 8'h80, 32'h0000_0100, 8, 16'h1234, 2'b00);
    cyc(20);
    `CHK(wide, 1'b0)
    `CHK(wr_cnt - c0, 0)
  endtask
  task do_write(input logic [15:0] d, input logic [1:0] m, input logic [1:0] keep);
    int c0;
    c0 = wr_cnt;
    psrpu_host_model_inst.send(1'b1, 8'h80, 32'h0000_0100, 8, d, m);
    cyc(20);
    `CHK(wr_cnt - c0 > 1, 1'b1)
    `CHK(last_mask & keep, m & keep)
    `CHK(last_wdata & {{8{keep[1]}}, 8'hff}, d & {{8{keep[1]}}, 8'hff})
  endtask
  task t_reg_read;
    int c0;
    c0 = oe_cnt;
    psrpu_host_model_inst.send(1'b1, 8'h40, 32'h0000_0008, 16, 16'h0000, 2'b00);
    cyc(20);
    `CHK(oe_cnt - c0 > 0, 1'b1)
    `CHK(adq_out, 16'h0001)
    `CHK(lane_oe, 2'b00)
  endtask
  task t_mem_write;
    do_write(16'h5aa5, 2'b01, 2'b01);
    do_write(16'h3cc3, 2'b00, 2'b01);
    set_width(8'h40);
    do_write(16'h5aa5, 2'b10, 2'b11);
    global_reset(4);
  endtask
  task t_refresh;
    int c0;
    c0 = ref_cnt;
    cyc(1560);
    `CHK(ref_cnt - c0 >= 1 && ref_cnt - c0 <= 3, 1'b1)
    @(posedge core_clk_in);
    hot <= 1'b1;
    cyc(20);
    c0 = ref_cnt;
    cyc(1560);
    `CHK(ref_cnt - c0 >= 7 && ref_cnt - c0 <= 9, 1'b1)
  endtask
  initial begin
    #100us;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    t_power_up();
    t_width_and_reset();
    t_reg_read();
    t_standby();
    t_mem_write();
    t_refresh();
    give_verdict();
  end
endmodule // testbench
